// >>> count_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module count_pin_model (
  input wire logic aclk,
  input wire logic watchdog_tick,
  input wire logic watchdog_restart,
  output logic external_count_input,
  output logic watchdog_base_tick
);
  // ------
  // Pin and tick drive
  // ------
  int wd_seen = 0;
  int restarts = 0;

  initial begin
    external_count_input = 1'b0;
    watchdog_base_tick = 1'b0;
  end

  always @(posedge aclk) begin
    if (watchdog_tick) wd_seen <= wd_seen + 1;
    if (watchdog_restart) restarts <= restarts + 1;
  end

  // Each level held 8 clocks, past the sync chain
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (8) @(posedge aclk);
      external_count_input <= !external_count_input;
    end
    repeat (8) @(posedge aclk);
  endtask

  task automatic base(input int n);
    repeat (n) begin
      @(posedge aclk);
      watchdog_base_tick <= 1'b1;
      @(posedge aclk);
      watchdog_base_tick <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
endmodule

`default_nettype wire

// >>> edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic settled;

  // ----------------------------------------------------------------
  // Three-stage capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign settled = (s2_reg == s3_reg);

  // ----------------------------------------------------------------
  // One pulse per accepted change
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= settled && s3_reg && !level_reg; // RQ16
      fall <= settled && !s3_reg && level_reg; // RQ16
      if (settled) begin
        level_reg <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

// >>> tb_eight_bit_timer_with_shared_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_zero_cfg.svh"

module tb_eight_bit_timer_with_shared_prescaler;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic pin;
  logic base_tick;
  logic wd_tick;
  logic wd_restart;
  logic irq;
  logic [31:0] rd_val;
  logic [1:0] rs;
  int miscompares = 0;
  int n_checks = 0;

  timer_zero #(.INSTR_DIV(4), .ADDR_W(8)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .external_count_input(pin), .watchdog_base_tick(base_tick),
    .watchdog_tick(wd_tick), .watchdog_restart(wd_restart), .irq(irq)
  );

  count_pin_model partner (
    .aclk(aclk), .watchdog_tick(wd_tick), .watchdog_restart(wd_restart),
    .external_count_input(pin), .watchdog_base_tick(base_tick)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ------
  // Bus and check tasks
  // ------
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hF);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bvalid && bready) break;
      bready <= 1'b1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rvalid && rready) break;
      rready <= 1'b1;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    rd_val = rdata;
    rs = rresp;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic test_reset();
    rd(`TZ_OFF_CONFIG);
    check(rd_val[7:0], `TZ_CONFIG_RESET);
    rd(`TZ_OFF_IRQ_STATUS);
    check(rd_val[7:0], 8'h00);
    rd(`TZ_OFF_COUNT);
    check(rd_val[7:0], `TZ_COUNT_RESET);
    wr(`TZ_OFF_COUNT, 8'hA5);
    wr(`TZ_OFF_COUNT, 8'h11, 4'h0);
    rd(`TZ_OFF_COUNT);
    check(rd_val[7:0], 8'hA5);
    rd(8'h14);
    check({6'h0, rs}, {6'h0, timer_zero_pkg::RESP_SLVERR});
    check(rd_val[7:0], 8'h00);
    wr(8'h14, 8'h5A);
    check({6'h0, rs}, {6'h0, timer_zero_pkg::RESP_SLVERR});
  endtask

  task automatic rate_case(input logic [7:0] cfg, input int win,
                           input logic [7:0] exp);
    logic [7:0] a;
    wr(`TZ_OFF_CONFIG, cfg);
    repeat (win / 2) @(posedge aclk);
    rd(`TZ_OFF_COUNT);
    a = rd_val[7:0];
    // Sample edges exactly win clocks apart
    repeat (win - 2) @(posedge aclk);
    rd(`TZ_OFF_COUNT);
    check(rd_val[7:0] - a, exp);
  endtask

  task automatic test_rates();
    rate_case(8'h08, 40, 8'd10);
    for (int r = 0; r < 8; r++) begin
      rate_case({5'h00, 3'(r)}, 8 << (r + 1), 8'd2);
    end
  endtask

  task automatic test_clear_on_write();
    wr(`TZ_OFF_CONFIG, 8'h07);
    wr(`TZ_OFF_COUNT, 8'h00);
    repeat (4) begin
      repeat (600) @(posedge aclk);
      rd(`TZ_OFF_COUNT);
      check(rd_val[7:0], 8'h00);
      wr(`TZ_OFF_COUNT, 8'h00);
    end
  endtask

  task automatic test_holdoff();
    logic [7:0] d;
    wr(`TZ_OFF_CONFIG, 8'h08);
    wr(`TZ_OFF_COUNT, 8'h40);
    // Forty clocks after the load give eight counts, two ticks lost to hold-off
    repeat (39) @(posedge aclk);
    rd(`TZ_OFF_COUNT);
    d = rd_val[7:0] - 8'h40;
    check(d, 8'd8);
  endtask

  task automatic edge_case(input logic fall_sel, input int n,
                           input logic [3:0] lo = 4'h8);
    logic [7:0] a;
    logic [7:0] e;
    wr(`TZ_OFF_CONFIG, {2'b00, 1'b1, fall_sel, lo});
    rd(`TZ_OFF_COUNT);
    a = rd_val[7:0];
    e = (pin == fall_sel) ? 8'((n + 1) / 2) : 8'(n / 2);
    // Timer-side prescaler at 1:2 halves an even edge count
    if (!lo[3]) e = e >> 1;
    partner.toggle(n);
    rd(`TZ_OFF_COUNT);
    check(rd_val[7:0] - a, e);
  endtask

  task automatic test_overflow();
    logic [7:0] a;
    wr(`TZ_OFF_CONFIG, 8'h08);
    wr(`TZ_OFF_IRQ_MASK, 8'h00);
    wr(`TZ_OFF_COUNT, 8'hFE);
    repeat (40) @(posedge aclk);
    rd(`TZ_OFF_IRQ_STATUS);
    check(rd_val[7:0], 8'h04);
    check({7'h0, irq}, 8'h00);
    wr(`TZ_OFF_IRQ_MASK, 8'hFF);
    rd(`TZ_OFF_IRQ_MASK);
    check(rd_val[7:0], 8'h04);
    check({7'h0, irq}, 8'h01);
    wr(`TZ_OFF_CTRL, 8'h01);
    rd(`TZ_OFF_COUNT);
    a = rd_val[7:0];
    repeat (40) @(posedge aclk);
    rd(`TZ_OFF_COUNT);
    check(rd_val[7:0], a);
    wr(`TZ_OFF_IRQ_STATUS, 8'h04);
    rd(`TZ_OFF_IRQ_STATUS);
    check(rd_val[7:0], 8'h00);
    check({7'h0, irq}, 8'h00);
    wr(`TZ_OFF_CTRL, 8'h00);
  endtask

  task automatic test_watchdog();
    int w;
    int r;
    r = partner.restarts;
    wr(`TZ_OFF_CTRL, 8'h02);
    wr(`TZ_OFF_COUNT, 8'h00);
    wr(`TZ_OFF_CONFIG, 8'h0A);
    wr(`TZ_OFF_CTRL, 8'h02);
    w = partner.wd_seen;
    partner.base(3);
    wr(`TZ_OFF_CTRL, 8'h02);
    partner.base(3);
    check(8'(partner.wd_seen - w), 8'h00);
    partner.base(1);
    check(8'(partner.wd_seen - w), 8'h01);
    wr(`TZ_OFF_CONFIG, 8'h08);
    w = partner.wd_seen;
    partner.base(3);
    check(8'(partner.wd_seen - w), 8'h03);
    check(8'(partner.restarts - r), 8'h03);
  endtask

  // ------
  // Main sequence
  // ------
  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset();
    test_edges();
    test_rates();
    test_clear_on_write();
    test_holdoff();
    test_overflow();
    test_watchdog();
    finish_test();
  end

  task automatic test_edges();
    edge_case(1'b0, 3);
    edge_case(1'b1, 3);
    edge_case(1'b1, 2);
    edge_case(1'b0, 1);
    edge_case(1'b0, 4, 4'h0);
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
endmodule

`default_nettype wire

// >>> timer_zero.sv
// Notes on behaviour
// RQ1: Eight-bit up counter, software read and write.
// RQ2: Timer mode counts every instruction cycle.
// RQ3: Counting held off two cycles after write.
// RQ4: Counter mode counts external input edges.
// RQ5: One prescaler, timer or watchdog, never both.
// RQ6: Three-bit rate picks eight timer division ratios.
// RQ7: Watchdog assignment gives timer one-to-one rate.
// RQ8: Prescaler count hidden from software entirely.
// RQ9: Count write clears prescaler when timer-assigned.
// RQ10: Watchdog clear resets prescaler when watchdog-assigned.
// RQ11: Software follows clearing sequence when reassigning.
// RQ12: Wrap sets overflow flag; software clears it.
// RQ13: Edge select one falling, zero rising.
// RQ14: Timer 1:2..1:256, watchdog 1:1..1:128.
// RQ15: Counter frozen during sleep.
// RQ16: External input synchronised and edge detected.
`timescale 1ns/1ps
`default_nettype none
`include "timer_zero_cfg.svh"

module timer_zero #(
  parameter int INSTR_DIV = `TZ_INSTR_DIV,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic external_count_input,
  input wire logic watchdog_base_tick,
  output logic watchdog_tick,
  output logic watchdog_restart,
  output logic irq
);

  generate
    if (INSTR_DIV < 1 || INSTR_DIV > 255) begin : g_bad_div
      $error("INSTR_DIV out of range");
    end
    if (ADDR_W < 5) begin : g_bad_addr
      $error("ADDR_W too narrow for the register map");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    addr_is = ({a[ADDR_W-1:2], 2'h0} == ADDR_W'(off));
  endfunction

  function automatic logic rate_hit(input logic [7:0] p,
                                    input timer_zero_pkg::rate_t ps,
                                    input logic for_timer);
    logic [8:0] m;
    m = for_timer ? (9'h002 << ps) : (9'h001 << ps);
    m = m - 9'h001;
    rate_hit = ((p & m[7:0]) == m[7:0]); // RQ14
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = addr_is(a, `TZ_OFF_COUNT) || addr_is(a, `TZ_OFF_CONFIG) ||
             addr_is(a, `TZ_OFF_IRQ_STATUS) ||
             addr_is(a, `TZ_OFF_IRQ_MASK) || addr_is(a, `TZ_OFF_CTRL);
  endfunction

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic do_write;

  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= timer_zero_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= mapped(awaddr_reg) ? timer_zero_pkg::RESP_OKAY
                                  : timer_zero_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic cnt_wr;
  logic cfg_wr;
  logic sts_wr;
  logic msk_wr;
  logic ctl_wr;

  assign cnt_wr = do_write && wlane_reg && addr_is(awaddr_reg, `TZ_OFF_COUNT);
  assign cfg_wr = do_write && wlane_reg &&
                  addr_is(awaddr_reg, `TZ_OFF_CONFIG);
  assign sts_wr = do_write && wlane_reg &&
                  addr_is(awaddr_reg, `TZ_OFF_IRQ_STATUS);
  assign msk_wr = do_write && wlane_reg &&
                  addr_is(awaddr_reg, `TZ_OFF_IRQ_MASK);
  assign ctl_wr = do_write && wlane_reg && addr_is(awaddr_reg, `TZ_OFF_CTRL);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] mask_reg;
  logic sleep_reg;
  logic wdt_clr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= `TZ_CONFIG_RESET;
      mask_reg <= 8'h00;
      sleep_reg <= 1'b0;
    end else begin
      if (cfg_wr) begin
        config_reg <= wdata_reg;
      end
      if (msk_wr) begin
        mask_reg <= wdata_reg & (8'h01 << `TZ_IRQ_OVERFLOW);
      end
      if (ctl_wr) begin
        sleep_reg <= wdata_reg[`TZ_CTRL_SLEEP];
      end
    end
  end

  assign wdt_clr = ctl_wr && wdata_reg[`TZ_CTRL_WDT_CLEAR];

  logic clock_source;
  logic source_edge;
  logic presc_assign;
  timer_zero_pkg::rate_t rate;

  assign clock_source = config_reg[`TZ_CFG_CLOCK_SOURCE];
  assign source_edge = config_reg[`TZ_CFG_SOURCE_EDGE];
  assign presc_assign = config_reg[`TZ_CFG_PRESC_ASSIGN];
  assign rate = config_reg[`TZ_CFG_RATE_HI:`TZ_CFG_RATE_LO];

  // ----------------------------------------------------------------
  // Instruction cycle divider
  // ----------------------------------------------------------------
  logic [7:0] div_reg;
  logic instr_tick;

  assign instr_tick = (div_reg == 8'(INSTR_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || instr_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Count source and prescaler
  // ----------------------------------------------------------------
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic src_tick;
  logic [7:0] presc_reg;
  logic presc_clr;
  logic presc_step;
  logic count_tick;

  edge_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(external_count_input),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign ext_edge = source_edge ? ext_fall : ext_rise; // RQ13
  // Sleep stops the source, so nothing reaches the counter
  assign src_tick = !sleep_reg &&
                    (clock_source ? ext_edge : instr_tick); // RQ2 RQ4 RQ15

  assign presc_clr = (cnt_wr && !presc_assign) || // RQ9
                     (wdt_clr && presc_assign); // RQ10
  assign presc_step = presc_assign ? watchdog_base_tick : src_tick; // RQ5

  always_ff @(posedge aclk) begin
    if (!aresetn || presc_clr) begin
      presc_reg <= 8'h00;
    end else if (presc_step) begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  // Watchdog assignment bypasses the prescaler entirely
  assign count_tick = presc_assign ? src_tick : // RQ7
                      (src_tick && rate_hit(presc_reg, rate, 1'b1)); // RQ6

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_tick <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_tick <= presc_assign && watchdog_base_tick &&
                       rate_hit(presc_reg, rate, 1'b0); // RQ5
      watchdog_restart <= wdt_clr; // RQ10
    end
  end

  // ----------------------------------------------------------------
  // Counter, write hold-off and overflow
  // ----------------------------------------------------------------
  timer_zero_pkg::count_t count_reg;
  logic [1:0] inhibit_reg;
  logic count_inc;
  logic [7:0] status_reg;
  logic ovf_set;

  assign count_inc = count_tick && (inhibit_reg == 2'h0); // RQ3
  assign ovf_set = count_inc && (count_reg == 8'hFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhibit_reg <= 2'h0;
    end else if (cnt_wr) begin
      inhibit_reg <= `TZ_WRITE_INHIBIT_CYC; // RQ3
    end else if (instr_tick && inhibit_reg != 2'h0) begin
      inhibit_reg <= inhibit_reg - 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= `TZ_COUNT_RESET;
    end else if (cnt_wr) begin
      count_reg <= wdata_reg; // RQ1
    end else if (count_inc) begin
      count_reg <= count_reg + 8'h01; // RQ1
    end
  end

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 8'h00;
    end else if (ovf_set) begin
      status_reg[`TZ_IRQ_OVERFLOW] <= 1'b1; // RQ12
    end else if (sts_wr) begin
      status_reg <= status_reg & ~wdata_reg; // RQ12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_val;

  // No address exposes the prescaler count
  always_comb begin
    rd_val = 8'h00;
    if (addr_is(araddr, `TZ_OFF_COUNT)) rd_val = count_reg;
    else if (addr_is(araddr, `TZ_OFF_CONFIG)) rd_val = config_reg;
    else if (addr_is(araddr, `TZ_OFF_IRQ_STATUS)) rd_val = status_reg;
    else if (addr_is(araddr, `TZ_OFF_IRQ_MASK)) rd_val = mask_reg;
    else if (addr_is(araddr, `TZ_OFF_CTRL)) rd_val = {7'h00, sleep_reg};
  end // RQ8

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= timer_zero_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_val};
      rresp <= mapped(araddr) ? timer_zero_pkg::RESP_OKAY
                              : timer_zero_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_write_holdoff: assert property ( // RQ3
    cnt_wr |=> inhibit_reg == 2'h2 && count_reg == $past(wdata_reg))
    else $error("count write did not load and arm hold-off");
  chk_holdoff_stable: assert property ( // RQ3
    (inhibit_reg != 2'h0 && !cnt_wr) |=> $stable(count_reg))
    else $error("count moved during write hold-off");
  chk_timer_rate: assert property ( // RQ2
    (presc_assign && !clock_source && !sleep_reg && instr_tick &&
     inhibit_reg == 2'h0 && !cnt_wr)
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("timer mode missed an instruction cycle");
  chk_ext_edge: assert property ( // RQ4
    (clock_source && !ext_edge && !cnt_wr) |=> $stable(count_reg))
    else $error("counter mode counted without an edge");
  chk_presc_div: assert property ( // RQ6
    (src_tick && !presc_assign && !presc_reg[0]) |-> !count_tick)
    else $error("timer prescaler ratio wrong");
  chk_presc_wr_clr: assert property ( // RQ9
    (cnt_wr && !presc_assign) |=> presc_reg == 8'h00)
    else $error("prescaler not cleared by count write");
  chk_presc_wdt_clr: assert property ( // RQ10
    (wdt_clr && presc_assign) |=> presc_reg == 8'h00 ##0 watchdog_restart)
    else $error("watchdog clear did not clear prescaler");
  chk_overflow_set: assert property ( // RQ12
    ovf_set |=> status_reg[`TZ_IRQ_OVERFLOW] ##1 irq == mask_reg[2])
    else $error("overflow flag not set on wrap");
  chk_sleep_freeze: assert property ( // RQ15
    (sleep_reg && !cnt_wr) |=> $stable(count_reg))
    else $error("counter moved during sleep");

  cov_overflow: cover property (ovf_set ##[1:4] irq);
  cov_ext_count: cover property (clock_source && count_inc);
  cov_write_then_count: cover property (cnt_wr ##[1:40] count_inc);
  cov_wdt_tick: cover property (watchdog_tick);

endmodule

`default_nettype wire

// >>> timer_zero_cfg.svh
`ifndef TIMER_ZERO_CFG_SVH
`define TIMER_ZERO_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TZ_OFF_COUNT 8'h00
`define TZ_OFF_CONFIG 8'h04
`define TZ_OFF_IRQ_STATUS 8'h08
`define TZ_OFF_IRQ_MASK 8'h0C
`define TZ_OFF_CTRL 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TZ_CFG_CLOCK_SOURCE 5
`define TZ_CFG_SOURCE_EDGE 4
`define TZ_CFG_PRESC_ASSIGN 3
`define TZ_CFG_RATE_HI 2
`define TZ_CFG_RATE_LO 0
`define TZ_IRQ_OVERFLOW 2
`define TZ_CTRL_SLEEP 0
`define TZ_CTRL_WDT_CLEAR 1

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define TZ_CONFIG_RESET 8'hFF
`define TZ_COUNT_RESET 8'h00
`define TZ_INSTR_DIV 4
`define TZ_WRITE_INHIBIT_CYC 2'h2

`endif

// >>> timer_zero_pkg.sv
`default_nettype none

package timer_zero_pkg;

  typedef logic [7:0] count_t;
  typedef logic [2:0] rate_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;

endpackage

`default_nettype wire
